//--- hw/mac_rx_filter_tx_status_regs.sv
// Receive filter/status and transmit mode/status registers with APB slave
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - With bits 15-11 clear, accept only address-match frames.
// - Copy whole receive register into accepted frame's descriptor status.
// - Clear receive bits 8-6 and 4-0 when next frame starts.
// - Software reset leaves both registers unchanged.
// - Bit 15 low rejects CRC/collision frames; high accepts, ignores collisions.
// - Bit 14 accepts frames under 64 bytes; hardware reset clears it.
// - Bit 13 accepts broadcasts plus matched frames; hardware reset clears it.
// - Bit 12 accepts every physical-destination frame.
// - Bit 11 accepts all multicast and all broadcast frames.
// - Loop field 11 selects transceiver loopback; software also sets config bit.
// - Set bit 8 for multicast, bit 7 for broadcast destination.
// - Set bit 6 when remaining words at or below end-of-buffer count.
// - Bit 5 follows carrier activity; bit 4 marks collision in frame.
// - Bit 3 on CRC alone; bit 2 instead with misalignment, only with CRC.
// - Set bit 1 on a good self-looped frame.
// - Set bit 0 only for error-free, full-length, collision-free frames.
// - Load transmit bits 15-12 from descriptor config at start.
// - At end set transmit bits 10-5 and 3-0 and write with collision count.
// - Clear transmit bits 9 and 5 after descriptor status written.
// - At next start clear bits 10, 7, 6, 1 and set bit 8.
// - Hardware reset sets transmit bits 8 and 0, clears bit 1.
module mac_rx_filter_tx_status_regs
  import mac_regs_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   clk_en,
  input  wire logic                   soft_reset,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Receive side
  input  wire logic                   carrier_sense,
  input  wire logic                   rx_start,
  input  wire logic                   rx_end,
  input  wire mac_regs_pkg::rx_frame_t rx_frame,
  input  wire logic [15:0]            remaining_buffer_words,
  input  wire logic [15:0]            end_of_buffer_count,
  output logic                        rx_accept,
  output logic      [15:0]            rx_descriptor_status_word,
  output logic                        rx_status_valid,
  output logic      [1:0]             loop_sel,
  // Transmit side
  input  wire logic                   tx_start,
  input  wire logic [15:0]            tx_descriptor_config_word,
  input  wire logic                   tx_end,
  input  wire logic [10:0]            tx_end_flags,
  input  wire logic [3:0]             tx_collision_count,
  input  wire logic                   tx_status_written,
  output logic      [15:0]            tx_mode,
  output logic      [15:0]            tx_descriptor_status_word,
  output logic                        tx_status_valid
);
  import mac_regs_pkg::*;

  state_t s_reg;
  state_t s_next;

  // ****************************************
  // Helpers
  // ****************************************
  // Address decode used by both read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] target);
    hit = (a == ADDR_W'(target));
  endfunction : hit

  // Filter decision for one frame
  function automatic logic filter_pass(input logic [15:0] ctl, input rx_frame_t f);
    logic by_addr;
    logic errs_ok;
    logic len_ok;
    by_addr = f.addr_match;
    if (ctl[RX_ACCEPT_BCAST] && f.is_bcast) by_addr = 1'b1;
    if (ctl[RX_ACCEPT_UCAST] && f.is_physical) by_addr = 1'b1;
    if (ctl[RX_ACCEPT_GROUP] && (f.is_group || f.is_bcast)) by_addr = 1'b1;
    errs_ok = ctl[RX_ACCEPT_FAULTY] || !(f.crc_err || f.collision);
    len_ok  = ctl[RX_ACCEPT_SHORT] || (f.length >= 16'(MIN_FRAME_BYTES));
    filter_pass = by_addr && errs_ok && len_ok;
  endfunction : filter_pass

  logic wr_en;
  logic rd_en;
  logic carrier_now;

  assign wr_en = psel && penable && pwrite && !s_reg.pready_reg;
  assign rd_en = psel && penable && !pwrite && !s_reg.pready_reg;
  assign carrier_now = s_reg.carrier_sync_reg[1];

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [15:0] rx_v;
    logic [15:0] tx_v;
    logic        good;
    rx_v = s_reg.rx_reg;
    tx_v = s_reg.tx_reg;
    good = 1'b0;
    s_next = s_reg;
    s_next.carrier_sync_reg = {s_reg.carrier_sync_reg[0], carrier_sense};
    s_next.rx_desc_valid_reg = 1'b0;
    s_next.tx_desc_valid_reg = 1'b0;
    s_next.pready_reg = 1'b0;
    s_next.pslverr_reg = 1'b0;
    // Carrier bit tracks the line continuously
    rx_v[RX_CARRIER] = carrier_now;
    // Receive frame start clears per-frame status
    if (rx_start) begin
      rx_v = rx_v & ~RX_CLEAR_MASK;
      rx_v[RX_COLLISION] = 1'b0;
    end
    // Receive frame end: record status and accept decision
    if (rx_end) begin
      rx_v[RX_GROUP_SEEN] = rx_frame.is_group && !rx_frame.is_bcast;
      rx_v[RX_BCAST_SEEN] = rx_frame.is_bcast;
      rx_v[RX_LAST_IN_BUF] = remaining_buffer_words <= end_of_buffer_count;
      rx_v[RX_COLLISION] = rx_frame.collision;
      rx_v[RX_CHECKSUM] = rx_frame.crc_err && !rx_frame.align_err;
      rx_v[RX_ALIGN] = rx_frame.crc_err && rx_frame.align_err;
      good = !rx_frame.crc_err && !rx_frame.align_err && !rx_frame.collision
             && (rx_frame.length >= 16'(MIN_FRAME_BYTES));
      rx_v[RX_GOOD] = good;
      rx_v[RX_LOOPED] = good && rx_frame.looped
                        && (s_reg.rx_reg[RX_LOOP_HI:RX_LOOP_LO] != LOOP_NONE);
      s_next.accept_reg = filter_pass(s_reg.rx_reg, rx_frame);
      if (filter_pass(s_reg.rx_reg, rx_frame)) begin
        s_next.rx_desc_reg = rx_v;
        s_next.rx_desc_valid_reg = 1'b1;
      end
    end
    // Clear after descriptor status is stored; a same-cycle end sets again
    if (tx_status_written) begin
      tx_v = tx_v & ~TX_WB_CLEAR_MASK;
    end
    // Transmit start loads mode and primes status
    if (tx_start) begin
      tx_v = (tx_v & ~TX_CONFIG_MASK) | (tx_descriptor_config_word & TX_CONFIG_MASK);
      tx_v = (tx_v & ~TX_START_CLEAR) | TX_START_SET;
    end
    // Transmit end captures status and reports it
    if (tx_end) begin
      tx_v = (tx_v & ~TX_STATUS_MASK) | ({5'h00, tx_end_flags} & TX_STATUS_MASK);
      s_next.tx_desc_reg = {tx_collision_count, tx_v[11:0]};
      s_next.tx_desc_valid_reg = 1'b1;
    end
    // APB write: control fields only; software reset does not touch these
    if (wr_en) begin
      s_next.pready_reg = 1'b1;
      if (hit(paddr, RX_FILTER_ADDR)) begin
        if (pstrb[1]) rx_v[15:9] = pwdata[15:9];
      end else if (hit(paddr, TX_MODE_ADDR)) begin
        if (pstrb[1]) tx_v[15:12] = pwdata[15:12];
      end else begin
        s_next.pslverr_reg = 1'b1;
      end
    end
    // APB read
    if (rd_en) begin
      s_next.pready_reg = 1'b1;
      s_next.prdata_reg = 32'h0000_0000;
      if (hit(paddr, RX_FILTER_ADDR)) s_next.prdata_reg = {16'h0000, s_reg.rx_reg};
      else if (hit(paddr, TX_MODE_ADDR)) s_next.prdata_reg = {16'h0000, s_reg.tx_reg};
      else s_next.pslverr_reg = 1'b1;
    end
    s_next.rx_reg = rx_v;
    s_next.tx_reg = tx_v;
  end

  // ****************************************
  // State register (hardware reset only)
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.rx_reg <= RX_RESET_VALUE;
      s_reg.tx_reg <= TX_RESET_VALUE;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state
  assign prdata  = s_reg.prdata_reg;
  assign pready  = s_reg.pready_reg;
  assign pslverr = s_reg.pslverr_reg;
  assign rx_accept = s_reg.accept_reg;
  assign rx_descriptor_status_word = s_reg.rx_desc_reg;
  assign rx_status_valid = s_reg.rx_desc_valid_reg;
  assign loop_sel = s_reg.rx_reg[RX_LOOP_HI:RX_LOOP_LO];
  assign tx_mode = s_reg.tx_reg;
  assign tx_descriptor_status_word = s_reg.tx_desc_reg;
  assign tx_status_valid = s_reg.tx_desc_valid_reg;

  // ****************************************
  // Assertions
  // ****************************************
  property p_rx_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && rx_start && !rx_end) |=> ((s_reg.rx_reg & RX_CLEAR_MASK) == 16'h0000);
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx status not cleared");

  property p_soft_reset;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && soft_reset && !wr_en && !tx_start && !tx_end && !tx_status_written)
        |=> (s_reg.tx_reg == $past(s_reg.tx_reg));
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset changed tx");

  property p_align;
    @(posedge pclk) disable iff (!presetn)
      s_reg.rx_reg[RX_ALIGN] |-> !s_reg.rx_reg[RX_CHECKSUM];
  endproperty
  a_align: assert property (p_align) else $error("align and crc both set");

  property p_desc_copy;
    @(posedge pclk) disable iff (!presetn)
      s_reg.rx_desc_valid_reg |-> (s_reg.rx_desc_reg == s_reg.rx_reg);
  endproperty
  a_desc_copy: assert property (p_desc_copy) else $error("descriptor copy mismatch");

  property p_good;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && rx_end && rx_frame.crc_err) |=> !s_reg.rx_reg[RX_GOOD];
  endproperty
  a_good: assert property (p_good) else $error("good set on crc error");

  property p_tx_start;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && tx_start && !tx_end && !wr_en)
        |=> (s_reg.tx_reg[8] && !s_reg.tx_reg[10] && !s_reg.tx_reg[1]
             && s_reg.tx_reg[15:12] == $past(tx_descriptor_config_word[15:12]));
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx start update wrong");

  property p_tx_wb;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && tx_status_written && !tx_end) |=> (!s_reg.tx_reg[9] && !s_reg.tx_reg[5]);
  endproperty
  a_tx_wb: assert property (p_tx_wb) else $error("tx bits 9/5 not cleared");

  property p_tx_end;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && tx_end) |=> (tx_status_valid
        && tx_descriptor_status_word[15:12] == $past(tx_collision_count));
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("tx status not reported");

  property p_reject_faulty;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && rx_end && !s_reg.rx_reg[RX_ACCEPT_FAULTY] && rx_frame.collision)
        |=> !rx_accept;
  endproperty
  a_reject_faulty: assert property (p_reject_faulty) else $error("faulty frame accepted");

endmodule : mac_rx_filter_tx_status_regs
`default_nettype wire

//--- common/mac_regs_pkg.sv
// Package: register map, field positions, reset values and carriers
package mac_regs_pkg;

  // ****************************************
  // Register map (index, byte address = 4*index)
  // ****************************************
  localparam logic [5:0]  RX_FILTER_IDX   = 6'h02;
  localparam logic [5:0]  TX_MODE_IDX     = 6'h03;
  localparam logic [11:0] RX_FILTER_ADDR  = 12'h008;
  localparam logic [11:0] TX_MODE_ADDR    = 12'h00c;

  // ****************************************
  // Receive register fields
  // ****************************************
  localparam int RX_ACCEPT_FAULTY = 15;
  localparam int RX_ACCEPT_SHORT  = 14;
  localparam int RX_ACCEPT_BCAST  = 13;
  localparam int RX_ACCEPT_UCAST  = 12;
  localparam int RX_ACCEPT_GROUP  = 11;
  localparam int RX_LOOP_HI       = 10;
  localparam int RX_LOOP_LO       = 9;
  localparam int RX_GROUP_SEEN    = 8;
  localparam int RX_BCAST_SEEN    = 7;
  localparam int RX_LAST_IN_BUF   = 6;
  localparam int RX_CARRIER       = 5;
  localparam int RX_COLLISION     = 4;
  localparam int RX_CHECKSUM      = 3;
  localparam int RX_ALIGN         = 2;
  localparam int RX_LOOPED        = 1;
  localparam int RX_GOOD          = 0;
  localparam logic [15:0] RX_CONTROL_MASK = 16'hfe00;
  localparam logic [15:0] RX_CLEAR_MASK   = 16'h01cf;
  localparam logic [15:0] RX_RESET_VALUE  = 16'h0000;
  localparam int          MIN_FRAME_BYTES = 64;

  // ****************************************
  // Transmit register fields
  // ****************************************
  localparam logic [15:0] TX_CONFIG_MASK   = 16'hf000;
  localparam logic [15:0] TX_STATUS_MASK   = 16'h07ef;
  localparam logic [15:0] TX_WB_CLEAR_MASK = 16'h0220;
  localparam logic [15:0] TX_START_CLEAR   = 16'h04c2;
  localparam logic [15:0] TX_START_SET     = 16'h0100;
  localparam logic [15:0] TX_RESET_VALUE   = 16'h0101;

  // Loop select encodings
  typedef enum logic [1:0] {
    LOOP_NONE  = 2'b00,
    LOOP_MAC   = 2'b01,
    LOOP_CODEC = 2'b10,
    LOOP_XCVR  = 2'b11
  } loop_sel_t;

  // Per-frame receive report from the MAC
  typedef struct packed {
    logic        is_group;
    logic        is_bcast;
    logic        is_physical;
    logic        addr_match;
    logic        crc_err;
    logic        align_err;
    logic        collision;
    logic        looped;
    logic [15:0] length;
  } rx_frame_t;

  // Block state
  typedef struct packed {
    logic [15:0] rx_reg;
    logic [15:0] tx_reg;
    logic [15:0] rx_desc_reg;
    logic        rx_desc_valid_reg;
    logic [15:0] tx_desc_reg;
    logic        tx_desc_valid_reg;
    logic        accept_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [1:0]  carrier_sync_reg;
  } state_t;

endpackage : mac_regs_pkg

//--- dv/mac_medium_model.sv
// Medium-side model: frame events, report lines and carrier
`timescale 1ns/1ps
`default_nettype none
module mac_medium_model
  import mac_regs_pkg::*;
(
  input  wire logic               pclk,
  output var  logic               carrier_sense,
  output var  logic               rx_start,
  output var  logic               rx_end,
  output var  mac_regs_pkg::rx_frame_t rx_frame,
  output var  logic [15:0]        remaining_buffer_words,
  output var  logic [15:0]        end_of_buffer_count
);
  // Idle line, no frame
  initial begin
    carrier_sense = 1'b0;
    rx_start = 1'b0;
    rx_end = 1'b0;
    rx_frame = '0;
    remaining_buffer_words = 16'h0000;
    end_of_buffer_count = 16'h0000;
  end

  // Frame opens: carrier up, one-cycle start pulse
  task begin_frame;
    @(posedge pclk);
    carrier_sense <= 1'b1;
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
  endtask : begin_frame

  // Frame closes: report valid only with the end pulse
  task finish_frame(input rx_frame_t f, input logic [15:0] rbw, input logic [15:0] eob);
    @(posedge pclk);
    rx_end <= 1'b1;
    rx_frame <= f;
    remaining_buffer_words <= rbw;
    end_of_buffer_count <= eob;
    @(posedge pclk);
    rx_end <= 1'b0;
    carrier_sense <= 1'b0;
    rx_frame <= ~f;                  // Stale report must not look valid
    remaining_buffer_words <= ~rbw;
    end_of_buffer_count <= ~eob;
  endtask : finish_frame
endmodule : mac_medium_model
`default_nettype wire

//--- dv/mac_rx_filter_tx_status_regs_test.sv
// Testbench: register access, receive filtering, transmit status
`timescale 1ns/1ps
`default_nettype none
module mac_rx_filter_tx_status_regs_test;
  import mac_regs_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, soft_reset = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, carrier_sense, rx_start, rx_end, rx_accept, rx_status_valid;
  rx_frame_t rx_frame;
  logic [15:0] remaining_buffer_words, end_of_buffer_count, rx_descriptor_status_word;
  logic [1:0] loop_sel;
  logic tx_start = 1'b0, tx_end = 1'b0, tx_status_written = 1'b0, tx_status_valid;
  logic [15:0] tx_descriptor_config_word = 16'h0, tx_mode, tx_descriptor_status_word;
  logic [10:0] tx_end_flags = 11'h0;
  logic [3:0] tx_collision_count = 4'h0;
  int mismatches = 0;
  int tests_run = 0;

  // Clock
  always #5 pclk = ~pclk;

  mac_rx_filter_tx_status_regs uut (.pclk, .presetn, .clk_en, .soft_reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .carrier_sense, .rx_start,
    .rx_end, .rx_frame, .remaining_buffer_words, .end_of_buffer_count, .rx_accept,
    .rx_descriptor_status_word, .rx_status_valid, .loop_sel, .tx_start,
    .tx_descriptor_config_word, .tx_end, .tx_end_flags, .tx_collision_count,
    .tx_status_written, .tx_mode, .tx_descriptor_status_word, .tx_status_valid);

  mac_medium_model med (.pclk, .carrier_sense, .rx_start, .rx_end, .rx_frame,
    .remaining_buffer_words, .end_of_buffer_count);

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Expected {accept, status word}; carrier is up during every frame
  function automatic logic [16:0] rx_exp(input logic [15:0] c, input rx_frame_t f,
                                         input logic lb);
    logic adr, ok, good;
    adr = f.addr_match | (f.is_bcast & (c[13] | c[11])) | (f.is_group & c[11])
        | (f.is_physical & c[12]);
    ok = adr & (c[15] | !(f.crc_err | f.collision)) & (c[14] | f.length >= MIN_FRAME_BYTES);
    good = !(f.crc_err | f.align_err | f.collision) & (f.length >= MIN_FRAME_BYTES);
    return {ok, c[15:9], f.is_group & !f.is_bcast, f.is_bcast, lb, 1'b1, f.collision,
            f.crc_err & !f.align_err, f.crc_err & f.align_err,
            good & f.looped & (c[10:9] != 2'b00), good};
  endfunction : rx_exp

  // Watchdog
  initial begin
    #300000;
    mismatches++;
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] q, r;
    logic e;
    logic [15:0] c, tx_exp;
    logic [16:0] x;
    rx_frame_t f;
    void'($urandom(32'h27e7a90c));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk("tx_mode reset", {16'h0, TX_RESET_VALUE}, {16'h0, tx_mode});
    rd(RX_FILTER_ADDR, q);
    chk("rx reset", 32'h0, q);
    rd(TX_MODE_ADDR, q);
    chk("tx reset", {16'h0, TX_RESET_VALUE}, q);
    for (int i = 0; i < 4; i++) begin
      wr(RX_FILTER_ADDR, {21'h0, i[1:0], 9'h0});
      repeat (2) @(posedge pclk);
      chk("loop_sel", {30'h0, i[1:0]}, {30'h0, loop_sel});
    end
    // Software reset must leave both registers alone
    wr(RX_FILTER_ADDR, 32'h0000ffff);
    wr(TX_MODE_ADDR, 32'h0000ffff);
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rd(RX_FILTER_ADDR, q);
    chk("rx soft reset", 32'h0000fe00, q);
    rd(TX_MODE_ADDR, q);
    chk("tx soft reset", 32'h0000f101, q);
    // Write with the lane 1 strobe off must not change the register
    pstrb <= 4'hd;
    wr(RX_FILTER_ADDR, 32'h00000000);
    pstrb <= 4'hf;
    rd(RX_FILTER_ADDR, q);
    chk("strobe off", 32'h0000fe00, q);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    // Random frames under random filter settings
    for (int i = 0; i < 48; i++) begin
      r = $urandom;
      c = {r[31:25], 9'h0};
      if (i % 4 == 0) c[15:11] = 5'h0;
      wr(RX_FILTER_ADDR, {16'h0, c});
      f.is_physical = (r[1:0] == 2'd0);
      f.is_bcast = (r[1:0] == 2'd2);
      f.is_group = (r[1:0] != 2'd0);
      f.addr_match = r[4];
      f.crc_err = r[5] & r[6];
      f.align_err = r[7] & r[8];
      f.collision = r[9] & r[10] & r[11];
      f.looped = r[12];
      if (f.looped) f.addr_match = 1'b1;
      f.length = (r[14:13] == 2'd0) ? 16'd63
               : 16'd64 + ((r[14:13] == 2'd1) ? 16'd0 : {7'h0, r[24:16]});
      med.begin_frame();
      rd(RX_FILTER_ADDR, q);
      chk("rx cleared", 32'h0, q & 32'h000001df);
      med.finish_frame(f, {13'h0, r[15], r[3:2]}, 16'd3);
      x = rx_exp(c, f, {r[15], r[3:2]} <= 3'd3);
      #1;
      chk("rx_accept", {31'h0, x[16]}, {31'h0, rx_accept});
      chk("rx_valid", {31'h0, x[16]}, {31'h0, rx_status_valid});
      if (x[16]) chk("rx status", {16'h0, x[15:0]}, {16'h0, rx_descriptor_status_word});
    end
    // Hardware reset in mid-run clears the accept bits and restores tx
    wr(RX_FILTER_ADDR, 32'h0000ffff);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(RX_FILTER_ADDR, q);
    chk("rx hw reset", {16'h0, RX_RESET_VALUE}, q);
    rd(TX_MODE_ADDR, q);
    chk("tx hw reset", {16'h0, TX_RESET_VALUE}, q);
    // Transmit start, end and write-back
    tx_exp = TX_RESET_VALUE;
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      @(posedge pclk);
      tx_start <= 1'b1;
      tx_descriptor_config_word <= r[15:0];
      @(posedge pclk);
      tx_start <= 1'b0;
      tx_descriptor_config_word <= ~r[15:0];
      tx_exp = {r[15:12], (tx_exp[11:0] & ~TX_START_CLEAR[11:0]) | TX_START_SET[11:0]};
      #1;
      chk("tx start", {16'h0, tx_exp}, {16'h0, tx_mode});
      @(posedge pclk);
      tx_end <= 1'b1;
      tx_end_flags <= r[26:16];
      tx_collision_count <= r[30:27];
      @(posedge pclk);
      tx_end <= 1'b0;
      tx_end_flags <= ~r[26:16];
      tx_exp = (tx_exp & ~TX_STATUS_MASK) | ({5'h0, r[26:16]} & TX_STATUS_MASK);
      #1;
      chk("tx end", {16'h0, tx_exp}, {16'h0, tx_mode});
      chk("tx valid", 32'h1, {31'h0, tx_status_valid});
      chk("tx desc", {16'h0, r[30:27], tx_exp[11:0]}, {16'h0, tx_descriptor_status_word});
      @(posedge pclk);
      tx_status_written <= 1'b1;
      @(posedge pclk);
      tx_status_written <= 1'b0;
      tx_exp = tx_exp & ~TX_WB_CLEAR_MASK;
      #1;
      chk("tx written", {16'h0, tx_exp}, {16'h0, tx_mode});
    end
    // Clock enable low freezes all state, a transmit start included
    @(posedge pclk);
    clk_en <= 1'b0;
    tx_start <= 1'b1;
    tx_descriptor_config_word <= ~tx_exp;
    repeat (2) @(posedge pclk);
    tx_start <= 1'b0;
    clk_en <= 1'b1;
    #1;
    chk("frozen tx", {16'h0, tx_exp}, {16'h0, tx_mode});
    report_and_stop();
  end
endmodule : mac_rx_filter_tx_status_regs_test
`default_nettype wire
